/* pkg/sswin_pkg.sv */
// Constants for the secondary status and memory window register bank.
// Assumes a plain register port and a single 100 MHz clock domain.
// ==========================================================================
// Notes on behaviour
// - A target-abort-sent flag sets when the bridge target-aborts on the secondary bus and clears only on a write of 1.
// - The two-bit decode speed field is read-only and returns the medium code 01b.
// - The master parity fault flag sets only when mastering with parity response enabled and PERR# is driven on a read or seen on a write.
// - In PCI-X mode the flag also sets on an uncorrectable split completion data error or a split write data error report.
// - The master parity fault flag stays set until software writes 1 to it; writing 0 leaves it.
// - With parity error response disabled the master parity fault flag never sets.
// - The fast back-to-back capable bit is read-only and reads 1.
// - The 66 MHz capable bit is read-only and reads 1; bit 6 and bits 4 to 0 read 0.
// - The window base field is compared with address bits 31 to 20 as an inclusive lower bound.
// - An upstream memory access inside the window goes to the secondary bus only with memory space enable set.
// - A secondary memory access outside the window goes upstream only with bus master enable set.
// - The window base register resets to zero and its low four bits read 0.
// - The window limit field is compared with address bits 31 to 20 as an exclusive upper bound.
package sswin_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // ========================================================================
  // Register offsets
  localparam logic [7:0] OFF_SEC_STATUS   = 8'h1e;
  localparam logic [7:0] OFF_WINDOW_BASE  = 8'h20;
  localparam logic [7:0] OFF_WINDOW_LIMIT = 8'h22;
  localparam logic [7:0] OFF_CONTROL      = 8'h04;
  localparam logic [7:0] OFF_IRQ_MASK     = 8'h40;

  // ========================================================================
  // Status field positions
  localparam int unsigned BIT_TAS   = 11;
  localparam int unsigned BIT_SPD_H = 10;
  localparam int unsigned BIT_SPD_L = 9;
  localparam int unsigned BIT_MPF   = 8;
  localparam int unsigned BIT_B2B   = 7;
  localparam int unsigned BIT_FAST  = 5;

  localparam logic [1:0] DECODE_SPEED_MEDIUM = 2'h1;

  // Control register bits
  localparam int unsigned CTL_MEM_EN   = 1;
  localparam int unsigned CTL_MAST_EN  = 2;
  localparam int unsigned CTL_PERR_EN  = 3;

  // Interrupt mask bits, same positions as the status flags
  localparam logic [15:0] IRQ_SRC_MASK = 16'h0900;

  // Window field
  localparam int unsigned WIN_HI = 15;
  localparam int unsigned WIN_LO = 4;

  // ========================================================================
  // Reset values
  localparam logic [15:0] RST_WINDOW_BASE  = 16'h0000;
  localparam logic [15:0] RST_WINDOW_LIMIT = 16'h0000;
  localparam logic [15:0] RST_CONTROL      = 16'h0000;
  localparam logic [15:0] RST_IRQ_MASK     = 16'h0000;

endpackage

/* logic/sswin_decode.sv */
// Window decode for the memory base and limit pair.
// Assumes base and limit come straight from registers; fully combinational.
`timescale 1ns/1ps
module sswin_decode
  import sswin_pkg::*;
(
  input  wire logic [11:0] base_i,
  input  wire logic [11:0] limit_i,
  input  wire logic [31:0] addr_i,
  output logic             inside_o
);

  wire logic above_base;
  wire logic below_limit;

  assign above_base  = addr_i[31:20] >= base_i;
  assign below_limit = addr_i[31:20] <  limit_i;
  assign inside_o    = above_base && below_limit;

endmodule

/* logic/sswin_top.sv */
// Secondary status flags, memory window registers and forwarding decisions.
// Assumes synchronous register port, strobes one cycle long, never both at once.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module sswin_top
  import sswin_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  // Secondary bus events
  input  wire logic              target_abort_sent_i,
  input  wire logic              is_master_i,
  input  wire logic              perr_driven_read_i,
  input  wire logic              perr_seen_write_i,
  input  wire logic              pcix_mode_i,
  input  wire logic              split_data_err_i,
  input  wire logic              split_write_err_i,
  // Upstream link memory request
  input  wire logic              up_req_i,
  input  wire logic [31:0]       up_addr_i,
  output logic                   up_fwd_o,
  // Secondary bus memory request
  input  wire logic              sec_req_i,
  input  wire logic [31:0]       sec_addr_i,
  output logic                   sec_fwd_o,
  // Interrupt
  output logic                   irq_o
);

  // ========================================================================
  // Register state
  logic [15:0] window_base_reg;
  logic [15:0] window_limit_reg;
  logic [15:0] control_reg;
  logic [15:0] irq_mask_reg;
  logic        tas_flag_reg;
  logic        mpf_flag_reg;
  logic [15:0] rdata_reg;
  logic        up_fwd_reg;
  logic        sec_fwd_reg;
  logic        irq_reg;

  // ========================================================================
  // Address decode
  wire logic hit_status;
  wire logic hit_base;
  wire logic hit_limit;
  wire logic hit_control;
  wire logic hit_mask;

  assign hit_status  = addr_i == OFF_SEC_STATUS;
  assign hit_base    = addr_i == OFF_WINDOW_BASE;
  assign hit_limit   = addr_i == OFF_WINDOW_LIMIT;
  assign hit_control = addr_i == OFF_CONTROL;
  assign hit_mask    = addr_i == OFF_IRQ_MASK;

  wire logic wr_status;
  wire logic wr_base;
  wire logic wr_limit;
  wire logic wr_control;
  wire logic wr_mask;

  assign wr_status  = wr_i && hit_status;
  assign wr_base    = wr_i && hit_base;
  assign wr_limit   = wr_i && hit_limit;
  assign wr_control = wr_i && hit_control;
  assign wr_mask    = wr_i && hit_mask;

  // ========================================================================
  // Control bits
  wire logic mem_en;
  wire logic mast_en;
  wire logic perr_en;

  assign mem_en  = control_reg[CTL_MEM_EN];
  assign mast_en = control_reg[CTL_MAST_EN];
  assign perr_en = control_reg[CTL_PERR_EN];

  // ========================================================================
  // Status events
  wire logic mpf_classic;
  wire logic mpf_pcix;
  wire logic mpf_set;
  wire logic tas_clr;
  wire logic mpf_clr;

  assign mpf_classic = is_master_i && (perr_driven_read_i || perr_seen_write_i);
  assign mpf_pcix    = pcix_mode_i && (split_data_err_i || split_write_err_i);
  assign mpf_set     = perr_en && (mpf_classic || mpf_pcix);
  assign tas_clr     = wr_status && wdata_i[BIT_TAS];
  assign mpf_clr     = wr_status && wdata_i[BIT_MPF];

  // Set beats clear so an event in the clearing cycle is kept
  wire logic tas_next;
  wire logic mpf_next;

  assign tas_next = target_abort_sent_i || (tas_flag_reg && !tas_clr);
  assign mpf_next = mpf_set || (mpf_flag_reg && !mpf_clr);

  // ========================================================================
  // Status word
  wire logic [15:0] status_word;

  assign status_word = {4'h0,
                        tas_flag_reg,
                        DECODE_SPEED_MEDIUM,
                        mpf_flag_reg,
                        1'b1,
                        1'b0,
                        1'b1,
                        5'h00};

  // ========================================================================
  // Read mux; unmapped offsets read zero
  wire logic [15:0] rd_mux;

  assign rd_mux = hit_status  ? status_word      :
                  hit_base    ? window_base_reg  :
                  hit_limit   ? window_limit_reg :
                  hit_control ? control_reg      :
                  hit_mask    ? irq_mask_reg     : 16'h0000;

  wire logic [15:0] rdata_next;

  assign rdata_next = rd_i ? rd_mux : 16'h0000;

  // ========================================================================
  // Window decode, shared by both directions
  wire logic up_inside;
  wire logic sec_inside;

  sswin_decode u_up_dec (
    .base_i   (window_base_reg[WIN_HI:WIN_LO]),
    .limit_i  (window_limit_reg[WIN_HI:WIN_LO]),
    .addr_i   (up_addr_i),
    .inside_o (up_inside)
  );

  sswin_decode u_sec_dec (
    .base_i   (window_base_reg[WIN_HI:WIN_LO]),
    .limit_i  (window_limit_reg[WIN_HI:WIN_LO]),
    .addr_i   (sec_addr_i),
    .inside_o (sec_inside)
  );

  wire logic up_fwd_next;
  wire logic sec_fwd_next;

  assign up_fwd_next  = up_req_i && up_inside && mem_en;
  assign sec_fwd_next = sec_req_i && !sec_inside && mast_en;

  // ========================================================================
  // Interrupt
  wire logic [15:0] irq_pending;
  wire logic        irq_next;

  assign irq_pending = {4'h0, tas_next, 2'h0, mpf_next, 8'h00} & irq_mask_reg & IRQ_SRC_MASK;
  assign irq_next    = |irq_pending;

  // ========================================================================
  // Writable registers; low nibble of window registers is held at zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      window_base_reg  <= RST_WINDOW_BASE;
      window_limit_reg <= RST_WINDOW_LIMIT;
    end else begin
      if (wr_base) begin
        window_base_reg <= {wdata_i[WIN_HI:WIN_LO], 4'h0};
      end
      if (wr_limit) begin
        window_limit_reg <= {wdata_i[WIN_HI:WIN_LO], 4'h0};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      control_reg  <= RST_CONTROL;
      irq_mask_reg <= RST_IRQ_MASK;
    end else begin
      if (wr_control) begin
        control_reg <= wdata_i;
      end
      if (wr_mask) begin
        irq_mask_reg <= wdata_i & IRQ_SRC_MASK;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tas_flag_reg <= 1'b0;
      mpf_flag_reg <= 1'b0;
    end else begin
      tas_flag_reg <= tas_next;
      mpf_flag_reg <= mpf_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg   <= 16'h0000;
      up_fwd_reg  <= 1'b0;
      sec_fwd_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      rdata_reg   <= rdata_next;
      up_fwd_reg  <= up_fwd_next;
      sec_fwd_reg <= sec_fwd_next;
      irq_reg     <= irq_next;
    end
  end

  assign rdata_o   = rdata_reg;
  assign up_fwd_o  = up_fwd_reg;
  assign sec_fwd_o = sec_fwd_reg;
  assign irq_o     = irq_reg;

  // ========================================================================
  // Checks
  a_tas_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(tas_flag_reg) && !$past(tas_clr) |-> tas_flag_reg)
    else $error("target abort flag dropped without clear");

  a_tas_capture: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    target_abort_sent_i |=> tas_flag_reg)
    else $error("target abort event not recorded");

  a_speed_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_i && hit_status |=> rdata_o[BIT_SPD_H:BIT_SPD_L] == 2'h1)
    else $error("decode speed code wrong");

  a_mpf_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(mpf_flag_reg) |-> $past(perr_en) && ($past(mpf_classic) || $past(mpf_pcix)))
    else $error("parity flag set without cause");

  a_mpf_pcix: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    perr_en && pcix_mode_i && split_data_err_i |=> mpf_flag_reg)
    else $error("split completion error not recorded");

  a_mpf_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mpf_flag_reg && !mpf_clr |=> mpf_flag_reg)
    else $error("parity flag dropped without clear");

  a_mpf_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !perr_en && !mpf_flag_reg |=> !mpf_flag_reg)
    else $error("parity flag set while response disabled");

  a_status_const: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_i && hit_status |=> rdata_o[BIT_B2B] && rdata_o[BIT_FAST] && rdata_o[6:0] == 7'h20)
    else $error("fixed status bits wrong");

  a_base_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_i && hit_base |=> rdata_o[3:0] == 4'h0)
    else $error("base reserved bits nonzero");

  a_up_forward: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    up_fwd_o |-> $past(mem_en) && $past(up_req_i)
      && $past(up_addr_i[31:20]) >= $past(window_base_reg[15:4])
      && $past(up_addr_i[31:20]) < $past(window_limit_reg[15:4]))
    else $error("upstream forward outside window or disabled");

  a_sec_forward: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sec_req_i && mast_en && sec_addr_i[31:20] < window_base_reg[15:4] |=> sec_fwd_o)
    else $error("secondary forward missing below base");

  a_irq_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_mask_reg[BIT_TAS] && tas_flag_reg && !tas_clr |=> irq_o)
    else $error("interrupt not raised for masked-in flag");

  a_up_inside: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    up_req_i && mem_en && up_addr_i[31:20] >= window_base_reg[15:4]
      && up_addr_i[31:20] < window_limit_reg[15:4] |=> up_fwd_o)
    else $error("upstream access inside window not forwarded");

  a_up_below: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    up_req_i && up_addr_i[31:20] < window_base_reg[15:4] |=> !up_fwd_o)
    else $error("upstream access below base forwarded");

  a_up_above: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    up_req_i && up_addr_i[31:20] >= window_limit_reg[15:4] |=> !up_fwd_o)
    else $error("upstream access at or above limit forwarded");

  a_up_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !mem_en |=> !up_fwd_o)
    else $error("upstream forward with memory space disabled");

  a_sec_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !mast_en |=> !sec_fwd_o)
    else $error("secondary forward with bus master disabled");

  a_sec_inside: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sec_req_i && sec_addr_i[31:20] >= window_base_reg[15:4]
      && sec_addr_i[31:20] < window_limit_reg[15:4] |=> !sec_fwd_o)
    else $error("secondary access inside window forwarded");

  a_sec_above: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sec_req_i && mast_en && sec_addr_i[31:20] >= window_limit_reg[15:4] |=> sec_fwd_o)
    else $error("secondary forward missing above limit");

  a_fwd_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !up_req_i && !sec_req_i |=> !up_fwd_o && !sec_fwd_o)
    else $error("forward raised without a request");

  a_mpf_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    perr_en && is_master_i && perr_driven_read_i |=> mpf_flag_reg)
    else $error("read parity error not recorded");

  a_mpf_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    perr_en && is_master_i && perr_seen_write_i |=> mpf_flag_reg)
    else $error("write parity error not recorded");

  a_mpf_splitwr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    perr_en && pcix_mode_i && split_write_err_i |=> mpf_flag_reg)
    else $error("split write error not recorded");

  a_mpf_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_i && hit_status && wdata_i[BIT_MPF] && !mpf_set |=> !mpf_flag_reg)
    else $error("parity flag not cleared by write of one");

  a_tas_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_i && hit_status && wdata_i[BIT_TAS] && !target_abort_sent_i |=> !tas_flag_reg)
    else $error("target abort flag not cleared by write of one");

  a_reserved_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_i && hit_status |=> !rdata_o[6] && rdata_o[4:0] == 5'h00)
    else $error("reserved status bits nonzero");

  a_rdata_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !rd_i |=> rdata_o == 16'h0000)
    else $error("read data stood beyond its cycle");

  a_irq_mpf: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_mask_reg[BIT_MPF] && mpf_flag_reg && !mpf_clr |=> irq_o)
    else $error("interrupt not raised for parity flag");

  a_irq_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    irq_mask_reg == 16'h0000 |=> !irq_o)
    else $error("interrupt raised while fully masked");

endmodule

/* verification/sswin_far_model.sv */
// Far-side model: secondary bus agent raising error and mode events.
// Assumes the bench asks for one event burst at a time.
`timescale 1ns/1ps
module sswin_far_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       go_i,
  input  wire logic [6:0] pat_i,
  output logic      [6:0] ev_o
);
  // ==========================================================================
  // Event burst
  // One cycle only, like a single bus termination; level bits drop with it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ev_o <= 7'h00;
    end else begin
      ev_o <= go_i ? pat_i : 7'h00;
    end
  end
endmodule

/* verification/secondary_status_and_mem_window_test.sv */
// Self-checking bench for the secondary status and memory window bank.
// Assumes sswin_pkg is compiled first and the far-side model beside it.
`timescale 1ns/1ps
module secondary_status_and_mem_window_test
  import sswin_pkg::*;
;
  logic              clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic              wr_i = 1'b0;
  logic              rd_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic              go = 1'b0;
  logic [6:0]        pat = 7'h00;
  logic [6:0]        ev;
  logic              up_req_i = 1'b0;
  logic              sec_req_i = 1'b0;
  logic [31:0]       up_addr_i = '0;
  logic [31:0]       sec_addr_i = '0;
  logic              up_fwd_o;
  logic              sec_fwd_o;
  logic              irq_o;
  int                n_errors = 0;
  int                cmp_count = 0;
  logic [35:0]       rows [8];
  logic [6:0]        mpf_pats [4];

  sswin_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .target_abort_sent_i(ev[6]), .is_master_i(ev[5]),
    .perr_driven_read_i(ev[4]), .perr_seen_write_i(ev[3]), .pcix_mode_i(ev[2]),
    .split_data_err_i(ev[1]), .split_write_err_i(ev[0]), .up_req_i(up_req_i), .up_addr_i(up_addr_i),
    .up_fwd_o(up_fwd_o), .sec_req_i(sec_req_i), .sec_addr_i(sec_addr_i), .sec_fwd_o(sec_fwd_o),
    .irq_o(irq_o));
  sswin_far_model far (.clk_i(clk_i), .rst_n_i(rst_n_i), .go_i(go), .pat_i(pat), .ev_o(ev));

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk($sformatf("reg %h", a), exp, rdata_o);
  endtask
  task automatic fire(input logic [6:0] p);
    @(posedge clk_i);
    go <= 1'b1; pat <= p;
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    // Row: {mem en, master en, address, up forwarded, sec forwarded}
    rows = '{{2'b11, 32'h0ff0_0000, 2'b01}, {2'b11, 32'h1000_0000, 2'b10}, {2'b11, 32'h1fff_ffff, 2'b10},
             {2'b11, 32'h2000_0000, 2'b01}, {2'b00, 32'h1000_0000, 2'b00}, {2'b00, 32'h0ff0_0000, 2'b00},
             {2'b10, 32'h0ff0_0000, 2'b00}, {2'b01, 32'h1000_0000, 2'b00}};
    mpf_pats = '{7'b0110000, 7'b0101000, 7'b0000110, 7'b0000101};
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(OFF_SEC_STATUS, 16'h02a0);
    rd(OFF_WINDOW_BASE, 16'h0000);
    rd(8'h30, 16'h0000);
    rd(OFF_SEC_STATUS, 16'h02a0);
    @(posedge clk_i);
    #1 chk("rdata idle", 16'h0000, rdata_o);
    wr(OFF_WINDOW_BASE, 16'hffff);
    rd(OFF_WINDOW_BASE, 16'hfff0);
    wr(OFF_WINDOW_BASE, 16'h1000);
    wr(OFF_WINDOW_LIMIT, 16'h2000);
    foreach (rows[i]) begin
      wr(OFF_CONTROL, {13'h0, rows[i][34], rows[i][35], 1'b0});
      @(posedge clk_i);
      up_req_i <= 1'b1; sec_req_i <= 1'b1;
      up_addr_i <= rows[i][33:2]; sec_addr_i <= rows[i][33:2];
      @(posedge clk_i);
      up_req_i <= 1'b0; sec_req_i <= 1'b0;
      #1 chk("up_fwd", {15'h0, rows[i][1]}, {15'h0, up_fwd_o});
      chk("sec_fwd", {15'h0, rows[i][0]}, {15'h0, sec_fwd_o});
    end
    // Parity response off: every error is ignored
    wr(OFF_CONTROL, 16'h0000);
    foreach (mpf_pats[i]) fire(mpf_pats[i]);
    rd(OFF_SEC_STATUS, 16'h02a0);
    wr(OFF_CONTROL, 16'h0008);
    fire(7'b0011000);
    fire(7'b0000010);
    rd(OFF_SEC_STATUS, 16'h02a0);
    foreach (mpf_pats[i]) begin
      fire(mpf_pats[i]);
      rd(OFF_SEC_STATUS, 16'h03a0);
      wr(OFF_SEC_STATUS, 16'h0000);
      rd(OFF_SEC_STATUS, 16'h03a0);
      wr(OFF_SEC_STATUS, 16'h0100);
      rd(OFF_SEC_STATUS, 16'h02a0);
    end
    // Target abort with the interrupt unmasked, then masked
    wr(OFF_IRQ_MASK, 16'h0900);
    fire(7'b1000000);
    rd(OFF_SEC_STATUS, 16'h0aa0);
    chk("irq on", 16'h0001, {15'h0, irq_o});
    wr(OFF_SEC_STATUS, 16'h0100);
    rd(OFF_SEC_STATUS, 16'h0aa0);
    wr(OFF_IRQ_MASK, 16'h0000);
    @(posedge clk_i);
    #1 chk("irq masked", 16'h0000, {15'h0, irq_o});
    wr(OFF_SEC_STATUS, 16'h0800);
    rd(OFF_SEC_STATUS, 16'h02a0);
    rd(OFF_SEC_STATUS, 16'h02a0);
    // Mid-run reset with a flag and the interrupt up: all must fall back
    wr(OFF_IRQ_MASK, 16'h0900);
    fire(7'b1000000);
    repeat (2) @(posedge clk_i);
    #1 chk("irq before reset", 16'h0001, {15'h0, irq_o});
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1 chk("irq reset", 16'h0000, {15'h0, irq_o});
    rd(OFF_WINDOW_BASE, 16'h0000);
    rd(OFF_SEC_STATUS, 16'h02a0);
    print_verdict();
  end
endmodule
